//--- pin_cnt_model.sv
// model of the channel pins and the counter that feed the block
module pin_cnt_model (
   input wire logic CLK,
   input wire logic run,
   input wire logic load,
   input wire logic [15:0] load_val,
   input wire logic [3:0] pin_set,
   input wire logic [3:0] pin_o,
   input wire logic [3:0] pin_oe,
   output logic [15:0] cnt,
   output logic [3:0] pin_i
);
   always_ff @(posedge CLK) begin
      if (load) begin
         cnt <= load_val;
      end else if (run) begin
         cnt <= cnt + 16'h0001;
      end
   end

   // device drive wins, else the outside level
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         pin_i[i] = pin_oe[i] ? pin_o[i] : pin_set[i];
      end
   end
endmodule : pin_cnt_model

//--- timer_ch4_io_control.sv
// i/o function select, compare outputs and capture for one timer channel
//
// Operation
// R1 - high control bits 7:4 select register b, bits 3:0 register a
// R2 - low control bits 7:4 select register d, bits 3:0 register c
// R3 - top bit 0: compare; bit 2 initial level; 00 undriven, 01 low
// R4 - compare mode 10 drives the pin high on each match
// R5 - compare mode 11 inverts the pin on each match
// R6 - top bit 1: capture from own pin; 00 latches on rising edge
// R7 - capture mode 01 latches on each falling edge
// R8 - capture with bit 1 set latches on both edges
// R9 - buffer b mode set: register d does neither capture nor compare
// R10 - buffer a mode set: register c does neither capture nor compare
// R11 - capture copies counter; match when counter equals register
//
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
module timer_ch4_io_control #(
   parameter int CW = 16
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic [timer_io_pkg::ADDR_W-1:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   input wire logic [timer_io_pkg::ADDR_W-1:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY,
   input wire logic [CW-1:0] CNT,
   input wire logic [3:0] PIN_I,
   output logic [3:0] PIN_O,
   output logic [3:0] PIN_OE
);
   import timer_io_pkg::*;

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic aw_v_q, w_v_q, bvalid_q, rvalid_q;
   logic [ADDR_W-1:0] aw_a_q;
   logic [31:0] wd_q, rdata_q, wmask, rd_v;
   logic [3:0] ws_q;
   logic [1:0] bresp_q, rresp_q;
   logic go;
   logic [7:0] io_hi_q, io_lo_q;
   logic [1:0] buf_q;
   logic [CW-1:0] gr_q [4];
   logic [3:0] fn [4];
   logic [3:0] s1_q, s2_q, s3_q, lvl_q, eq_q, pin_q, evt_q;
   logic [3:0] rise, fall, mt, cap, en, oe, wr_fld, gr_wr;

   function automatic logic hit(input logic [ADDR_W-1:0] a);
      return a[1:0] == 2'b00 && a < OFS_END;
   endfunction : hit

   // ----------------------------------------------------------------
   // write channel
   // ----------------------------------------------------------------
   assign AWREADY = !aw_v_q && !bvalid_q;
   assign WREADY = !w_v_q && !bvalid_q;
   assign go = aw_v_q && w_v_q;

   always_ff @(posedge CLK) begin
      if (RST) begin
         aw_v_q <= 1'b0;
         aw_a_q <= '0;
      end else if (AWVALID && AWREADY) begin
         aw_v_q <= 1'b1;
         aw_a_q <= AWADDR;
      end else if (go) begin
         aw_v_q <= 1'b0;
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         w_v_q <= 1'b0;
         wd_q <= '0;
         ws_q <= '0;
      end else if (WVALID && WREADY) begin
         w_v_q <= 1'b1;
         wd_q <= WDATA;
         ws_q <= WSTRB;
      end else if (go) begin
         w_v_q <= 1'b0;
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
      end else if (go) begin
         bvalid_q <= 1'b1;
         bresp_q <= hit(aw_a_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (BREADY) begin
         bvalid_q <= 1'b0;
      end
   end

   assign BVALID = bvalid_q;
   assign BRESP = bresp_q;

   always_comb begin
      for (int k = 0; k < 4; k++) begin
         wmask[8*k +: 8] = {8{ws_q[k]}};
      end
   end

   // ----------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (RST) begin
         io_hi_q <= CTRL_RST;
      end else if (go && ws_q[0] && aw_a_q == OFS_CTRL_HI) begin
         io_hi_q <= wd_q[7:0];
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         io_lo_q <= CTRL_RST;
      end else if (go && ws_q[0] && aw_a_q == OFS_CTRL_LO) begin
         io_lo_q <= wd_q[7:0];
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         buf_q <= MODE_RST;
      end else if (go && ws_q[0] && aw_a_q == OFS_MODE) begin
         buf_q <= wd_q[1:0];
      end
   end

   assign fn[0] = io_hi_q[0 +: FLD_W]; // R1
   assign fn[1] = io_hi_q[FLD_W +: FLD_W]; // R1
   assign fn[2] = io_lo_q[0 +: FLD_W]; // R2
   assign fn[3] = io_lo_q[FLD_W +: FLD_W]; // R2

   // ----------------------------------------------------------------
   // per general register logic
   // ----------------------------------------------------------------
   for (genvar i = 0; i < 4; i++) begin : g_ch
      oc_act_t act;
      logic agree;

      assign act = oc_act_t'(fn[i][1:0]);
      assign en[i] = !((i == 2 && buf_q[BIT_BUFA]) || // R10
         (i == 3 && buf_q[BIT_BUFB])); // R9
      assign oe[i] = en[i] && !fn[i][BIT_CAP] && act != OC_OFF; // R3
      assign wr_fld[i] = go && ws_q[0] &&
         aw_a_q == ((i < 2) ? OFS_CTRL_HI : OFS_CTRL_LO);
      assign gr_wr[i] = go &&
         aw_a_q == OFS_GR_BASE + 6'(i) * OFS_GR_STEP;
      // match only on the first cycle of equality
      assign mt[i] = en[i] && !fn[i][BIT_CAP] &&
         CNT == gr_q[i] && !eq_q[i]; // R11

      // a level change counts once stages two and three agree
      assign agree = s2_q[i] == s3_q[i];
      assign rise[i] = agree && s3_q[i] && !lvl_q[i];
      assign fall[i] = agree && !s3_q[i] && lvl_q[i];
      assign cap[i] = en[i] && fn[i][BIT_CAP] && (fn[i][BIT_BOTH] ?
         (rise[i] || fall[i]) : // R8
         (fn[i][BIT_FALL] ? fall[i] : rise[i])); // R6 R7

      always_ff @(posedge CLK) begin
         s1_q[i] <= PIN_I[i];
         s2_q[i] <= s1_q[i];
         s3_q[i] <= s2_q[i];
      end

      always_ff @(posedge CLK) begin
         if (RST) begin
            lvl_q[i] <= s3_q[i];
         end else if (agree) begin
            lvl_q[i] <= s3_q[i];
         end
      end

      always_ff @(posedge CLK) begin
         if (RST) begin
            eq_q[i] <= 1'b0;
         end else begin
            eq_q[i] <= CNT == gr_q[i];
         end
      end

      always_ff @(posedge CLK) begin
         if (RST) begin
            pin_q[i] <= 1'b0;
         end else if (wr_fld[i]) begin
            pin_q[i] <= wd_q[(i % 2) * FLD_W + BIT_INIT]; // R3
         end else if (mt[i]) begin
            case (act)
               OC_LOW: pin_q[i] <= 1'b0; // R3
               OC_HIGH: pin_q[i] <= 1'b1; // R4
               OC_TOGGLE: pin_q[i] <= !pin_q[i]; // R5
               default: pin_q[i] <= pin_q[i];
            endcase
         end
      end

      // capture wins over a software write in the same cycle
      always_ff @(posedge CLK) begin
         if (RST) begin
            gr_q[i] <= '0;
         end else if (cap[i]) begin
            gr_q[i] <= CNT; // R11
         end else if (gr_wr[i]) begin
            gr_q[i] <= (gr_q[i] & ~wmask[CW-1:0]) |
               (wd_q[CW-1:0] & wmask[CW-1:0]);
         end
      end
   end

   assign PIN_O = pin_q;
   assign PIN_OE = oe;

   // ----------------------------------------------------------------
   // event flags, write one to clear, new event wins
   // ----------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (RST) begin
         evt_q <= '0;
      end else if (go && ws_q[0] && aw_a_q == OFS_STAT) begin
         evt_q <= (evt_q & ~wd_q[3:0]) | mt | cap;
      end else begin
         evt_q <= evt_q | mt | cap;
      end
   end

   // ----------------------------------------------------------------
   // read channel
   // ----------------------------------------------------------------
   assign ARREADY = !rvalid_q;

   always_comb begin
      rd_v = '0;
      case (ARADDR)
         OFS_CTRL_HI: rd_v[7:0] = io_hi_q;
         OFS_CTRL_LO: rd_v[7:0] = io_lo_q;
         OFS_MODE: rd_v[1:0] = buf_q;
         OFS_STAT: rd_v[7:0] = {lvl_q, evt_q};
         OFS_GR_BASE: rd_v = 32'(gr_q[0]);
         OFS_GR_BASE + 6'h04: rd_v = 32'(gr_q[1]);
         OFS_GR_BASE + 6'h08: rd_v = 32'(gr_q[2]);
         OFS_GR_BASE + 6'h0c: rd_v = 32'(gr_q[3]);
         default: rd_v = '0;
      endcase
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= RESP_OKAY;
      end else if (ARVALID && ARREADY) begin
         rvalid_q <= 1'b1;
         rdata_q <= rd_v;
         rresp_q <= hit(ARADDR) ? RESP_OKAY : RESP_SLVERR;
      end else if (RREADY) begin
         rvalid_q <= 1'b0;
      end
   end

   assign RVALID = rvalid_q;
   assign RDATA = rdata_q;
   assign RRESP = rresp_q;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   AST_A_HIGH: assert property ( // R1
      io_hi_q[3:0] == 4'h2 && mt[0] && !wr_fld[0] |=> PIN_O[0])
      else $error("a: compare high did not set pin");

   AST_D_LOW: assert property ( // R2
      io_lo_q[7:4] == 4'h5 && mt[3] && !wr_fld[3] |=> !PIN_O[3])
      else $error("d: compare low did not clear pin");

   AST_INIT_LVL: assert property ( // R3
      $changed(io_hi_q[3:0]) && !io_hi_q[BIT_CAP]
      |-> PIN_O[0] == io_hi_q[BIT_INIT])
      else $error("a: initial level not loaded");

   AST_OE_SEL: assert property ( // R3
      PIN_OE[1] == (!io_hi_q[7] && io_hi_q[5:4] != 2'b00))
      else $error("b: pin enable wrong for field");

   AST_B_HIGH: assert property ( // R4
      io_hi_q[7:4] == 4'h6 && CNT == gr_q[1] && !eq_q[1] &&
      !wr_fld[1] |=> PIN_O[1] ##1 ($stable(PIN_O[1]) || $past(wr_fld[1])))
      else $error("b: compare high failed");

   AST_TOGGLE: assert property ( // R5
      io_hi_q[1:0] == 2'b11 && !io_hi_q[3] && mt[0] && !wr_fld[0]
      |=> PIN_O[0] != $past(PIN_O[0]))
      else $error("a: toggle did not invert");

   AST_CAP_RISE: assert property ( // R6
      io_hi_q[3:0] == 4'h8 && $rose(lvl_q[0]) |-> gr_q[0] == $past(CNT))
      else $error("a: rising capture missed");

   AST_CAP_FALL: assert property ( // R7
      io_hi_q[3:0] == 4'hd && fall[0] |=> gr_q[0] == $past(CNT))
      else $error("a: falling capture missed");

   AST_CAP_BOTH: assert property ( // R8
      io_hi_q[7] && io_hi_q[5] && (rise[1] || fall[1])
      |=> gr_q[1] == $past(CNT))
      else $error("b: both-edge capture missed");

   AST_BUF_D: assert property ( // R9
      buf_q[BIT_BUFB] && !gr_wr[3] |-> !PIN_OE[3] ##1 $stable(gr_q[3]))
      else $error("d: active while buffering");

   AST_BUF_C: assert property ( // R10
      buf_q[BIT_BUFA] && !wr_fld[2] |-> !PIN_OE[2] ##1 $stable(PIN_O[2]))
      else $error("c: active while buffering");

   AST_MATCH_ONCE: assert property ( // R11
      mt[2] |=> !mt[2])
      else $error("c: match repeated without new equality");

   AST_BHOLD: assert property (
      BVALID && !BREADY |=> BVALID && $stable(BRESP))
      else $error("write response dropped early");

   COV_CAP: cover property (cap[0] ##1 RVALID);
   COV_TOGGLE: cover property (
      mt[1] && io_hi_q[5:4] == 2'b11 ##[1:50] mt[1]);
   COV_BUF: cover property (buf_q[BIT_BUFA] && cap[2] == 1'b0 &&
      io_lo_q[3] && rise[2]);

endmodule : timer_ch4_io_control

//--- timer_ch4_io_control_tb.sv
// self-checking bench for the channel i/o control block
module timer_ch4_io_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import timer_io_pkg::*;

   logic clk, rst, awvalid, wvalid, bready, arvalid, rready, run, load;
   logic awready, wready, bvalid, arready, rvalid;
   logic [5:0] awaddr, araddr;
   logic [31:0] wdata, rdata, d, e;
   logic [3:0] wstrb, pin_set, pin_i, pin_o, pin_oe, nib;
   logic [1:0] bresp, rresp, r;
   logic [15:0] cnt, load_val;
   logic [3:0] caps [5] = '{4'h8, 4'h9, 4'ha, 4'hd, 4'hb};
   int err_count, n_checks;

   timer_ch4_io_control #(.CW(16)) u_timer_ch4_io_control (
      .CLK(clk), .RST(rst), .AWADDR(awaddr), .AWVALID(awvalid),
      .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid),
      .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
      .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
      .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
      .CNT(cnt), .PIN_I(pin_i), .PIN_O(pin_o), .PIN_OE(pin_oe)
   );

   pin_cnt_model u_pin_cnt_model (
      .CLK(clk), .run(run), .load(load), .load_val(load_val),
      .pin_set(pin_set), .pin_o(pin_o), .pin_oe(pin_oe), .cnt(cnt),
      .pin_i(pin_i)
   );

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("FAIL %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic final_report();
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : final_report

   task automatic stuck();
      err_count++;
      $display("FAIL %0t: bus answer missing", $time);
      final_report();
   endtask : stuck

   task automatic wr(input logic [5:0] a, input logic [31:0] v);
      int n;
      @(posedge clk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      r = bresp;
      if (n == 40) stuck();
   endtask : wr

   task automatic rd(input logic [5:0] a);
      int n;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rready <= 1'b0;
      d = rdata;
      r = rresp;
      if (n == 40) stuck();
   endtask : rd

   task automatic set_cnt(input logic [15:0] v, input logic go);
      @(posedge clk);
      load_val <= v;
      load <= 1'b1;
      run <= go;
      @(posedge clk);
      load <= 1'b0;
   endtask : set_cnt

   function automatic logic [5:0] ctl(input int f);
      return (f < 2) ? OFS_CTRL_HI : OFS_CTRL_LO;
   endfunction : ctl

   function automatic logic [31:0] fld(input int f, input logic [3:0] v);
      return f[0] ? {24'h0, v, 4'h0} : {28'h0, v};
   endfunction : fld

   // ----------------------------------------------------------------
   // sequence
   // ----------------------------------------------------------------
   initial begin
      rst <= 1'b1;
      {awvalid, wvalid, bready, arvalid, rready, run} <= 6'h00;
      // counter loads zero during reset so compare logic never sees x
      load <= 1'b1;
      awaddr <= 6'h00;
      araddr <= 6'h00;
      wdata <= 32'h0;
      wstrb <= 4'hf;
      pin_set <= 4'h0;
      load_val <= 16'h0000;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      load <= 1'b0;
      rd(OFS_CTRL_HI);
      chk(d, 32'h0);
      rd(OFS_CTRL_LO);
      chk(d, 32'h0);
      chk(32'(pin_oe), 32'h0);
      rd(OFS_END);
      chk(32'(r), 32'(RESP_SLVERR));
      wr(OFS_END, 32'h1);
      chk(32'(r), 32'(RESP_SLVERR));
      for (int f = 0; f < 4; f++) begin
         for (int k = 0; k < 8; k++) begin
            nib = 4'(k);
            set_cnt(16'h0000, 1'b0);
            wr(OFS_GR_BASE + 6'(4 * f), 32'h8);
            chk(32'(r), 32'(RESP_OKAY));
            wr(ctl(f), fld(f, nib));
            @(negedge clk);
            chk(32'(pin_oe[f]), 32'(nib[1:0] != 2'b00));
            if (nib[1:0] != 2'b00) chk(32'(pin_o[f]), 32'(nib[2]));
            set_cnt(16'h0000, 1'b1);
            repeat (16) @(posedge clk);
            run <= 1'b0;
            @(negedge clk);
            e = 32'(nib[1:0] == 2'b11 ? !nib[2] : nib[1]);
            if (nib[1:0] != 2'b00) chk(32'(pin_o[f]), e);
         end
      end
      for (int f = 0; f < 4; f++) begin
         for (int k = 0; k < 5; k++) begin
            nib = caps[k];
            wr(ctl(f), fld(f, nib));
            repeat (8) @(posedge clk);
            wr(OFS_GR_BASE + 6'(4 * f), 32'h0);
            set_cnt(16'h0011, 1'b0);
            pin_set[f] <= 1'b1;
            repeat (6) @(posedge clk);
            rd(OFS_GR_BASE + 6'(4 * f));
            e = (nib[1] | !nib[0]) ? 32'h11 : 32'h0;
            chk(d, e);
            set_cnt(16'h0022, 1'b0);
            pin_set[f] <= 1'b0;
            repeat (6) @(posedge clk);
            rd(OFS_GR_BASE + 6'(4 * f));
            chk(d, (nib[1] | nib[0]) ? 32'h22 : e);
         end
      end
      wr(OFS_MODE, 32'h3);
      for (int f = 2; f < 4; f++) begin
         wr(OFS_GR_BASE + 6'(4 * f), 32'h8);
      end
      wr(OFS_CTRL_LO, 32'h22);
      rd(OFS_CTRL_LO);
      chk(d, 32'h22);
      // first pass buffered: no drive, no match; second pass normal
      for (int m = 0; m < 2; m++) begin
         set_cnt(16'h0000, 1'b1);
         repeat (16) @(posedge clk);
         run <= 1'b0;
         @(negedge clk);
         chk(32'(pin_oe[3:2]), (m == 1) ? 32'h3 : 32'h0);
         chk(32'(pin_o[3:2]), (m == 1) ? 32'h3 : 32'h0);
         wr(OFS_MODE, 32'h0);
      end
      // reset in mid run clears written registers and pin drive
      @(posedge clk);
      rst <= 1'b1;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      rd(OFS_CTRL_HI);
      chk(d, 32'h0);
      rd(OFS_CTRL_LO);
      chk(d, 32'h0);
      chk(32'(pin_oe), 32'h0);
      chk(32'(pin_o), 32'h0);
      final_report();
   end
endmodule : timer_ch4_io_control_tb

//--- timer_io_pkg.sv
// constants and types shared by the channel i/o control block
package timer_io_pkg;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam int ADDR_W = 6;
   localparam logic [5:0] OFS_CTRL_HI = 6'h00;
   localparam logic [5:0] OFS_CTRL_LO = 6'h04;
   localparam logic [5:0] OFS_MODE = 6'h08;
   localparam logic [5:0] OFS_STAT = 6'h0c;
   localparam logic [5:0] OFS_GR_BASE = 6'h10;
   localparam logic [5:0] OFS_GR_STEP = 6'h04;
   localparam logic [5:0] OFS_END = 6'h20;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [1:0] MODE_RST = 2'h0;

   // ----------------------------------------------------------------
   // field layout
   // ----------------------------------------------------------------
   localparam int FLD_W = 4;
   localparam int BIT_CAP = 3;
   localparam int BIT_INIT = 2;
   localparam int BIT_BOTH = 1;
   localparam int BIT_FALL = 0;
   localparam int BIT_BUFA = 0;
   localparam int BIT_BUFB = 1;
   localparam int ST_PIN_POS = 4;

   // ----------------------------------------------------------------
   // bus responses and compare actions
   // ----------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      OC_OFF = 2'b00,
      OC_LOW = 2'b01,
      OC_HIGH = 2'b10,
      OC_TOGGLE = 2'b11
   } oc_act_t;

endpackage : timer_io_pkg
